/* File: src/peripheral_clock_select.sv */
// Peripheral clock source selection and division, top level
//
// Function
// - One reference clock input feeds both PLL controllers.
// - PHY source 0 aux, 1 bypass domain, 2 PLL1 out1, 3 PLL2 out1.
// - Bypass domain clock is reference divided by three.
// - USB controller gets one PLL output and the PHY-made clock.
// - Keypad clock is divided aux or the RTC oscillator clock.
// - Divided aux is aux over divider ratio plus one, shared.
// - Power/RTC clock is divided aux or the RTC oscillator clock.
// - Codec clock is PLL2 output four over codec ratio plus one.
// - Video processing from PLL1/PLL2 output two; bus from PLL1 out3.
// - Image codec processing from PLL1 out4, bus from PLL1 out3.
// - CPU clock is PLL1 or PLL2 output two per select.
// - DRAM clock is PLL1 out7 or PLL2 out3 per select.
// - DRAM source runs at twice interface rate; u_dram_half halves it.
// - Aux domain runs at the reference rate, bypassing both PLLs.
// - Slow peripherals take their clock from the aux domain.
// - CPU select of one moves the CPU to PLL2 output two.
// - Both PLL controllers start in bypass after reset.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_select
	import clock_select_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [31:0]       rdata_o,
	// Source clocks from outside
	input  wire logic              ref_clk_i,
	input  wire logic              rtc_osc_i,
	input  wire logic              pll1_out1_i,
	input  wire logic              pll1_out2_i,
	input  wire logic              pll1_out3_i,
	input  wire logic              pll1_out4_i,
	input  wire logic              pll1_out7_i,
	input  wire logic              pll2_out1_i,
	input  wire logic              pll2_out2_i,
	input  wire logic              pll2_out3_i,
	input  wire logic              pll2_out4_i,
	input  wire logic              usb_phy_made_clk_i,
	// PLL controller feeds and mode
	output logic                   pll1_ref_o,
	output logic                   pll2_ref_o,
	output logic                   pll1_bypass_o,
	output logic                   pll2_bypass_o,
	// USB clocks
	output logic                   usb_phy_clk_o,
	output logic [PHY_FREQ_W-1:0]  phy_frequency_code_o,
	output logic                   usb_ctrl_pll_clk_o,
	output logic                   usb_ctrl_phy_clk_o,
	// Peripheral clocks
	output logic                   aux_domain_clk_o,
	output logic                   keypad_clk_o,
	output logic                   rtc_subsys_clk_o,
	output logic                   codec_clk_o,
	output logic                   video_proc_clk_o,
	output logic                   video_bus_clk_o,
	output logic                   image_proc_clk_o,
	output logic                   image_bus_clk_o,
	output logic                   cpu_clk_o,
	output logic                   dram_2x_clk_o,
	output logic                   dram_if_clk_o
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0]        peri_ctl_r;
	logic [31:0]        usb_phy_ctl_r;
	logic [31:0]        pll_ctl_r;
	logic [31:0]        status;
	logic [31:0]        rd_nxt;
	logic [SRC_NUM-1:0] src_raw;
	logic [SRC_NUM-1:0] sync1_r;
	logic [SRC_NUM-1:0] sync2_r;
	logic               bypass_clk;
	logic               aux_div_clk;

	clk_sel_if #(.N(4), .SW(2)) phy_if ();
	clk_sel_if #(.N(2), .SW(1)) key_if ();
	clk_sel_if #(.N(2), .SW(1)) rtc_if ();
	clk_sel_if #(.N(2), .SW(1)) video_if ();
	clk_sel_if #(.N(2), .SW(1)) cpu_if ();
	clk_sel_if #(.N(2), .SW(1)) dram_if ();

	// Register writes, reserved bits dropped on the way in
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			peri_ctl_r    <= PERI_CTL_RST;
			usb_phy_ctl_r <= USB_PHY_RST;
			pll_ctl_r     <= PLL_CTL_RST;
		end
		else if (wr_i)
		begin
			case (addr_i)
				PERI_CTL_ADDR: peri_ctl_r    <= wdata_i & PERI_CTL_MASK;
				USB_PHY_ADDR:  usb_phy_ctl_r <= wdata_i & USB_PHY_MASK;
				PLL_CTL_ADDR:  pll_ctl_r     <= wdata_i & PLL_CTL_MASK;
				default:       ;
			endcase
		end
	end

	// Status shows the sources the muxes actually run from
	always_comb
	begin
		status = '0;
		status[ST_PHY_LSB +: 2] = phy_if.active;
		status[ST_KEY_BIT]      = key_if.active[0];
		status[ST_RTC_BIT]      = rtc_if.active[0];
		status[ST_VIDEO_BIT]    = video_if.active[0];
		status[ST_CPU_BIT]      = cpu_if.active[0];
		status[ST_DRAM_BIT]     = dram_if.active[0];
		status[ST_BYP1_BIT]     = pll1_bypass_o;
		status[ST_BYP2_BIT]     = pll2_bypass_o;
	end

	// Read decode; unmapped addresses read zero
	always_comb
	begin
		case (addr_i)
			PERI_CTL_ADDR: rd_nxt = peri_ctl_r;
			USB_PHY_ADDR:  rd_nxt = usb_phy_ctl_r;
			PLL_CTL_ADDR:  rd_nxt = pll_ctl_r;
			STATUS_ADDR:   rd_nxt = status;
			default:       rd_nxt = '0;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			rdata_o <= '0;
		else
			rdata_o <= rd_i ? rd_nxt : '0;
	end

	// ------------------------------------------------------------
	// Source synchronisers
	// ------------------------------------------------------------
	// Sources above half of mclk alias; they arrive here already slow
	always_comb
	begin
		src_raw           = '0;
		src_raw[SRC_REF]  = ref_clk_i;
		src_raw[SRC_RTC]  = rtc_osc_i;
		src_raw[SRC_P1O1] = pll1_out1_i;
		src_raw[SRC_P1O2] = pll1_out2_i;
		src_raw[SRC_P1O3] = pll1_out3_i;
		src_raw[SRC_P1O4] = pll1_out4_i;
		src_raw[SRC_P1O7] = pll1_out7_i;
		src_raw[SRC_P2O1] = pll2_out1_i;
		src_raw[SRC_P2O2] = pll2_out2_i;
		src_raw[SRC_P2O3] = pll2_out3_i;
		src_raw[SRC_P2O4] = pll2_out4_i;
		src_raw[SRC_UPHY] = usb_phy_made_clk_i;
	end

	// Two stages; only the second is read by logic
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= src_raw;
			sync2_r <= sync1_r;
		end
	end

	// ------------------------------------------------------------
	// Pass-through clocks and control outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			pll1_ref_o           <= 1'b0;
			pll2_ref_o           <= 1'b0;
			aux_domain_clk_o     <= 1'b0;
			usb_ctrl_pll_clk_o   <= 1'b0;
			usb_ctrl_phy_clk_o   <= 1'b0;
			video_bus_clk_o      <= 1'b0;
			image_proc_clk_o     <= 1'b0;
			image_bus_clk_o      <= 1'b0;
			pll1_bypass_o        <= 1'b1;
			pll2_bypass_o        <= 1'b1;
			phy_frequency_code_o <= '0;
		end
		else
		begin
			pll1_ref_o           <= sync2_r[SRC_REF];
			pll2_ref_o           <= sync2_r[SRC_REF];
			aux_domain_clk_o     <= sync2_r[SRC_REF];
			usb_ctrl_pll_clk_o   <= sync2_r[SRC_P1O1];
			usb_ctrl_phy_clk_o   <= sync2_r[SRC_UPHY];
			video_bus_clk_o      <= sync2_r[SRC_P1O3];
			image_proc_clk_o     <= sync2_r[SRC_P1O4];
			image_bus_clk_o      <= sync2_r[SRC_P1O3];
			pll1_bypass_o        <= !pll_ctl_r[PLL1_EN_BIT];
			pll2_bypass_o        <= !pll_ctl_r[PLL2_EN_BIT];
			phy_frequency_code_o <= usb_phy_ctl_r[PHY_FREQ_LSB +: PHY_FREQ_W];
		end
	end

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	// Reference over three feeds the bypass-domain PHY option
	clk_divider #(.W(DIV_W)) u_bypass_div (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.src_i   (sync2_r[SRC_REF]),
		.ratio_i (BYPASS_RATIO),
		.clk_o   (bypass_clk)
	);

	// One divider shared by keypad and power/RTC paths
	clk_divider #(.W(DIV_W)) u_aux_div (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.src_i   (sync2_r[SRC_REF]),
		.ratio_i (div_field(peri_ctl_r, AUX_DIV_LSB)),
		.clk_o   (aux_div_clk)
	);

	clk_divider #(.W(DIV_W)) u_codec_div (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.src_i   (sync2_r[SRC_P2O4]),
		.ratio_i (div_field(peri_ctl_r, CODEC_DIV_LSB)),
		.clk_o   (codec_clk_o)
	);

	// DRAM interface clock is half of the selected 2x source
	clk_divider #(.W(DIV_W)) u_dram_half (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.src_i   (dram_if.clk),
		.ratio_i (DRAM_HALF_RATIO),
		.clk_o   (dram_if_clk_o)
	);

	// ------------------------------------------------------------
	// Source multiplexers
	// ------------------------------------------------------------
	assign phy_if.src   = {sync2_r[SRC_P2O1], sync2_r[SRC_P1O1], bypass_clk,
		sync2_r[SRC_REF]};
	assign phy_if.sel   = usb_phy_ctl_r[PHY_SRC_LSB +: 2];
	assign key_if.src   = {sync2_r[SRC_RTC], aux_div_clk};
	assign key_if.sel   = peri_ctl_r[KEY_SEL_BIT];
	assign rtc_if.src   = {sync2_r[SRC_RTC], aux_div_clk};
	assign rtc_if.sel   = peri_ctl_r[RTC_SEL_BIT];
	assign video_if.src = {sync2_r[SRC_P2O2], sync2_r[SRC_P1O2]};
	assign video_if.sel = peri_ctl_r[VIDEO_SEL_BIT];
	assign cpu_if.src   = {sync2_r[SRC_P2O2], sync2_r[SRC_P1O2]};
	assign cpu_if.sel   = peri_ctl_r[CPU_SEL_BIT];
	assign dram_if.src  = {sync2_r[SRC_P2O3], sync2_r[SRC_P1O7]};
	assign dram_if.sel  = peri_ctl_r[DRAM_SEL_BIT];

	glitch_free_mux #(.N(4), .SW(2)) u_phy_mux   (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(phy_if));
	glitch_free_mux #(.N(2), .SW(1)) u_key_mux   (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(key_if));
	glitch_free_mux #(.N(2), .SW(1)) u_rtc_mux   (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(rtc_if));
	glitch_free_mux #(.N(2), .SW(1)) u_video_mux (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(video_if));
	glitch_free_mux #(.N(2), .SW(1)) u_cpu_mux   (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(cpu_if));
	glitch_free_mux #(.N(2), .SW(1)) u_dram_mux  (.mclk_i(mclk_i), .rst_i(rst_i), .sel_if(dram_if));

	assign usb_phy_clk_o    = phy_if.clk;
	assign keypad_clk_o     = key_if.clk;
	assign rtc_subsys_clk_o = rtc_if.clk;
	assign video_proc_clk_o = video_if.clk;
	assign cpu_clk_o        = cpu_if.clk;
	assign dram_2x_clk_o    = dram_if.clk;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_ref_both;
		@(posedge mclk_i) disable iff (rst_i)
		##1 (pll1_ref_o == pll2_ref_o) && (pll1_ref_o == $past(sync2_r[SRC_REF]));
	endproperty
	a_ref_both: assert property (p_ref_both) else $error("PLL references differ");

	property p_phy_bypass;
		@(posedge mclk_i) disable iff (rst_i)
		((phy_if.active == PHY_SRC_BYPASS) && $rose(usb_phy_clk_o)) |-> $past(bypass_clk);
	endproperty
	a_phy_bypass: assert property (p_phy_bypass) else $error("PHY clock not from bypass");

	property p_phy_pll2;
		@(posedge mclk_i) disable iff (rst_i)
		((phy_if.active == PHY_SRC_PLL2) && $rose(usb_phy_clk_o)) |-> $past(sync2_r[SRC_P2O1]);
	endproperty
	a_phy_pll2: assert property (p_phy_pll2) else $error("PHY clock not from PLL2");

	property p_key_rtc;
		@(posedge mclk_i) disable iff (rst_i)
		(key_if.active[0] && $rose(keypad_clk_o)) |-> $past(sync2_r[SRC_RTC]);
	endproperty
	a_key_rtc: assert property (p_key_rtc) else $error("keypad clock not from RTC");

	property p_rtc_aux;
		@(posedge mclk_i) disable iff (rst_i)
		(!rtc_if.active[0] && $rose(rtc_subsys_clk_o)) |-> $past(aux_div_clk);
	endproperty
	a_rtc_aux: assert property (p_rtc_aux) else $error("RTC clock not from divided aux");

	property p_video_pll1;
		@(posedge mclk_i) disable iff (rst_i)
		(!video_if.active[0] && $rose(video_proc_clk_o)) |-> $past(sync2_r[SRC_P1O2]);
	endproperty
	a_video_pll1: assert property (p_video_pll1) else $error("video clock not from PLL1");

	property p_cpu_pll2;
		@(posedge mclk_i) disable iff (rst_i)
		(cpu_if.active[0] && $rose(cpu_clk_o)) |-> $past(sync2_r[SRC_P2O2]);
	endproperty
	a_cpu_pll2: assert property (p_cpu_pll2) else $error("CPU clock not from PLL2");

	property p_dram_pll1;
		@(posedge mclk_i) disable iff (rst_i)
		(!dram_if.active[0] && $rose(dram_2x_clk_o)) |-> $past(sync2_r[SRC_P1O7]);
	endproperty
	a_dram_pll1: assert property (p_dram_pll1) else $error("DRAM clock not from PLL1");

	property p_dram_half;
		@(posedge mclk_i) disable iff (rst_i)
		$rose(dram_if_clk_o) |-> $past(dram_2x_clk_o) && !$past(dram_2x_clk_o, 2);
	endproperty
	a_dram_half: assert property (p_dram_half) else $error("DRAM interface clock off 2x edge");

	property p_bypass_reset;
		@(posedge mclk_i)
		$fell(rst_i) |-> pll1_bypass_o && pll2_bypass_o;
	endproperty
	a_bypass_reset: assert property (p_bypass_reset) else $error("PLL not in bypass after reset");

endmodule // peripheral_clock_select
`default_nettype wire

/* File: src/clock_select_pkg.sv */
// Constants, register layout and helpers shared by the clock select design
package clock_select_pkg;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  PERI_CTL_ADDR  = 4'h0;
	localparam logic [3:0]  USB_PHY_ADDR   = 4'h4;
	localparam logic [3:0]  PLL_CTL_ADDR   = 4'h8;
	localparam logic [3:0]  STATUS_ADDR    = 4'hc;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int          DIV_W          = 8;
	localparam int          KEY_SEL_BIT    = 0;
	localparam int          RTC_SEL_BIT    = 1;
	localparam int          VIDEO_SEL_BIT  = 2;
	localparam int          CPU_SEL_BIT    = 3;
	localparam int          DRAM_SEL_BIT   = 4;
	localparam int          AUX_DIV_LSB    = 8;
	localparam int          CODEC_DIV_LSB  = 16;
	localparam logic [31:0] PERI_CTL_MASK  = 32'h00ff_ff1f;
	localparam logic [31:0] PERI_CTL_RST   = 32'h0000_0000;
	localparam int          PHY_SRC_LSB    = 0;
	localparam int          PHY_FREQ_LSB   = 4;
	localparam int          PHY_FREQ_W     = 4;
	localparam logic [31:0] USB_PHY_MASK   = 32'h0000_00f3;
	localparam logic [31:0] USB_PHY_RST    = 32'h0000_0000;
	localparam int          PLL1_EN_BIT    = 0;
	localparam int          PLL2_EN_BIT    = 1;
	localparam logic [31:0] PLL_CTL_MASK   = 32'h0000_0003;
	localparam logic [31:0] PLL_CTL_RST    = 32'h0000_0000;

	// Status word positions
	localparam int          ST_PHY_LSB     = 0;
	localparam int          ST_KEY_BIT     = 2;
	localparam int          ST_RTC_BIT     = 3;
	localparam int          ST_VIDEO_BIT   = 4;
	localparam int          ST_CPU_BIT     = 5;
	localparam int          ST_DRAM_BIT    = 6;
	localparam int          ST_BYP1_BIT    = 8;
	localparam int          ST_BYP2_BIT    = 9;

	// ------------------------------------------------------------
	// Source indices in the synchronised input vector
	// ------------------------------------------------------------
	localparam int SRC_REF  = 0;
	localparam int SRC_RTC  = 1;
	localparam int SRC_P1O1 = 2;
	localparam int SRC_P1O2 = 3;
	localparam int SRC_P1O3 = 4;
	localparam int SRC_P1O4 = 5;
	localparam int SRC_P1O7 = 6;
	localparam int SRC_P2O1 = 7;
	localparam int SRC_P2O2 = 8;
	localparam int SRC_P2O3 = 9;
	localparam int SRC_P2O4 = 10;
	localparam int SRC_UPHY = 11;
	localparam int SRC_NUM  = 12;

	// PHY source codes
	localparam logic [1:0] PHY_SRC_AUX    = 2'h0;
	localparam logic [1:0] PHY_SRC_BYPASS = 2'h1;
	localparam logic [1:0] PHY_SRC_PLL1   = 2'h2;
	localparam logic [1:0] PHY_SRC_PLL2   = 2'h3;

	// Fixed divider ratios (divide by ratio plus one)
	localparam logic [DIV_W-1:0] BYPASS_RATIO    = 8'h02;
	localparam logic [DIV_W-1:0] DRAM_HALF_RATIO = 8'h01;

	// Divider ratio field extraction
	function automatic logic [DIV_W-1:0] div_field(input logic [31:0] w, input int lsb);
		return w[lsb +: DIV_W];
	endfunction

endpackage

/* File: src/clk_sel_if.sv */
// Carrier between a source multiplexer and its user
`timescale 1ns/1ps
`default_nettype none
interface clk_sel_if #(
	parameter int N  = 2,
	parameter int SW = 1
);
	logic [N-1:0]  src;
	logic [SW-1:0] sel;
	logic          clk;
	logic [SW-1:0] active;

	modport mux  (input src, input sel, output clk, output active);
	modport user (output src, output sel, input clk, input active);
endinterface
`default_nettype wire

/* File: src/glitch_free_mux.sv */
// Clock source multiplexer that switches only between whole pulses
`timescale 1ns/1ps
`default_nettype none
module glitch_free_mux #(
	parameter int N  = 2,
	parameter int SW = 1
) (
	// Clock and reset
	input  wire logic  mclk_i,
	input  wire logic  rst_i,
	// Sources, select and output
	clk_sel_if.mux     sel_if
);

	typedef enum logic [0:0] {MUX_RUN = 1'b0, MUX_PARK = 1'b1} mux_state_e;

	mux_state_e     state_r;
	logic [SW-1:0]  cur_r;
	logic           out_r;

	// ------------------------------------------------------------
	// Switch sequence
	// ------------------------------------------------------------
	// Leave the old source only while low, join the new one only once low
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_r <= MUX_RUN;
			cur_r   <= '0;
			out_r   <= 1'b0;
		end
		else
		begin
			case (state_r)
				MUX_RUN:
				begin
					if ((sel_if.sel != cur_r) && !out_r)
					begin
						state_r <= MUX_PARK;
						cur_r   <= sel_if.sel;
						out_r   <= 1'b0;
					end
					else
						out_r <= sel_if.src[cur_r];
				end
				MUX_PARK:
				begin
					out_r <= 1'b0;
					if (!sel_if.src[cur_r])
						state_r <= MUX_RUN;
				end
				default:
				begin
					state_r <= MUX_RUN;
					out_r   <= 1'b0;
				end
			endcase
		end
	end

	assign sel_if.clk    = out_r;
	assign sel_if.active = cur_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_switch_req;
		(state_r == MUX_RUN) && (sel_if.sel != cur_r) && !out_r;
	endsequence

	sequence s_parked_low;
		(state_r == MUX_PARK) && !out_r;
	endsequence

	property p_mux_park;
		@(posedge mclk_i) disable iff (rst_i)
		s_switch_req |=> s_parked_low ##1 !out_r;
	endproperty
	a_mux_park: assert property (p_mux_park) else $error("mux output not held low on switch");

	property p_mux_hold_high;
		@(posedge mclk_i) disable iff (rst_i)
		out_r |=> $stable(cur_r);
	endproperty
	a_mux_hold_high: assert property (p_mux_hold_high) else $error("source changed mid pulse");

	property p_mux_rise_cause;
		@(posedge mclk_i) disable iff (rst_i)
		$rose(out_r) |-> $past(sel_if.src[cur_r]) && $past(state_r == MUX_RUN);
	endproperty
	a_mux_rise_cause: assert property (p_mux_rise_cause) else $error("output rose without source");

endmodule // glitch_free_mux
`default_nettype wire

/* File: src/clk_divider.sv */
// Divides a sampled clock level by ratio plus one
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	// Source and ratio
	input  wire logic         src_i,
	input  wire logic [W-1:0] ratio_i,
	// Divided level
	output logic              clk_o
);

	logic         prev_r;
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [W:0]   half;
	logic         rise;

	// Wrap check uses >= so a smaller new ratio cannot strand the count
	assign rise    = src_i && !prev_r;
	assign cnt_nxt = (cnt_r >= ratio_i) ? '0 : W'(cnt_r + 1'b1);
	assign half    = (W+1)'(({1'b0, ratio_i} + 1'b1) >> 1);

	// ------------------------------------------------------------
	// Edge count and output level
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			prev_r <= 1'b0;
			cnt_r  <= '0;
			clk_o  <= 1'b0;
		end
		else
		begin
			prev_r <= src_i;
			if (ratio_i == '0)
				clk_o <= src_i;
			else if (rise)
			begin
				cnt_r <= cnt_nxt;
				clk_o <= ({1'b0, cnt_nxt} < half);
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_div_wrap;
		@(posedge mclk_i) disable iff (rst_i)
		(rise && (ratio_i != '0) && (cnt_r >= ratio_i)) |=> (cnt_r == '0) && clk_o;
	endproperty
	a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap");

	property p_div_rise;
		@(posedge mclk_i) disable iff (rst_i)
		($rose(clk_o) && $past(ratio_i != '0)) |-> $past(rise);
	endproperty
	a_div_rise: assert property (p_div_rise) else $error("divided clock rose off a source edge");

endmodule // clk_divider
`default_nettype wire

/* File: test/src_clk_gen.sv */
// Source clock model: slow free-running clocks of distinct periods
`timescale 1ns/1ps
`default_nettype none
module src_clk_gen (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// Source levels, source i toggles every i+3 cycles
	output logic      [11:0] src_o
);
	logic [4:0] cnt_r [12];

	// Known levels from time zero
	initial
	begin
		src_o = '0;
		for (int i = 0; i < 12; i++)
			cnt_r[i] = 5'h00;
	end

	// Periods stay above two mclk cycles, so nothing aliases
	always @(posedge mclk_i)
		for (int i = 0; i < 12; i++)
			if (rst_i || cnt_r[i] == 5'(i + 2))
			begin
				cnt_r[i] <= '0;
				src_o[i] <= !rst_i && !src_o[i];
			end
			else
				cnt_r[i] <= cnt_r[i] + 5'h01;
endmodule // src_clk_gen
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the peripheral clock select block
`timescale 1ns/1ps
`default_nettype none
module tb_top import clock_select_pkg::*;;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic [3:0]  addr = '0;
	logic [31:0] wdata = '0;
	wire  [31:0] rdata;
	logic [31:0] v;
	wire  [11:0] src;
	wire  [3:0]  freq;
	wire  [1:0]  byp;
	wire  [15:0] o;
	logic [15:0] o_q = '0;
	logic [31:0] exp_q [$];
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          phy_per [4] = '{6, 18, 10, 20};

	// Clock, 4 ns period
	initial
		forever #2 mclk_i = ~mclk_i;

	src_clk_gen u_src (.mclk_i(mclk_i), .rst_i(rst_i), .src_o(src));

	peripheral_clock_select u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.ref_clk_i(src[0]), .rtc_osc_i(src[1]), .pll1_out1_i(src[2]),
		.pll1_out2_i(src[3]), .pll1_out3_i(src[4]), .pll1_out4_i(src[5]),
		.pll1_out7_i(src[6]), .pll2_out1_i(src[7]), .pll2_out2_i(src[8]),
		.pll2_out3_i(src[9]), .pll2_out4_i(src[10]), .usb_phy_made_clk_i(src[11]),
		.pll1_ref_o(o[14]), .pll2_ref_o(o[15]),
		.pll1_bypass_o(byp[0]), .pll2_bypass_o(byp[1]),
		.usb_phy_clk_o(o[0]), .phy_frequency_code_o(freq),
		.usb_ctrl_pll_clk_o(o[1]), .usb_ctrl_phy_clk_o(o[2]),
		.aux_domain_clk_o(o[3]), .keypad_clk_o(o[4]), .rtc_subsys_clk_o(o[5]),
		.codec_clk_o(o[6]), .video_proc_clk_o(o[7]), .video_bus_clk_o(o[8]),
		.image_proc_clk_o(o[9]), .image_bus_clk_o(o[10]), .cpu_clk_o(o[11]),
		.dram_2x_clk_o(o[12]), .dram_if_clk_o(o[13])
	);

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask

	// Expected word is noted now, compared by the watcher
	task automatic rd_reg(logic [3:0] a, logic [31:0] e);
		exp_q.push_back(e);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
	endtask

	// Cycles between two rising edges of output i
	task automatic per(int i, int e);
		int n;
		n = 0;
		do
			@(posedge mclk_i);
		while (!(o[i] && !o_q[i]));
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (!(o[i] && !o_q[i]));
		chk($sformatf("period %0d", i), e, n);
	endtask

	// Watcher: read data one cycle after the strobe; hang guard
	always @(posedge mclk_i)
	begin
		rd_q <= rd;
		o_q <= o;
		if (rd_q)
			chk("rdata", exp_q.pop_front(), rdata);
		else if (rdata !== 32'h0)
			chk("rdata idle", 32'h0, rdata);
		cyc++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end

	// Main sequence
	initial
	begin
		void'($urandom(69546));
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		chk("bypass", 32'h3, 32'(byp));
		rd_reg(PERI_CTL_ADDR, PERI_CTL_RST);
		rd_reg(USB_PHY_ADDR, USB_PHY_RST);
		rd_reg(PLL_CTL_ADDR, PLL_CTL_RST);
		rd_reg(STATUS_ADDR, 32'h0000_0300);
		rd_reg(4'h2, 32'h0);
		repeat (20) @(posedge mclk_i);
		per(14, 6);
		per(15, 6);
		per(3, 6);
		per(1, 10);
		per(2, 28);
		per(8, 14);
		per(9, 16);
		per(10, 14);
		$display("test defaults done");
		for (int s = 0; s < 4; s++)
		begin
			wr_reg(USB_PHY_ADDR, 32'(s * 17));
			rd_reg(USB_PHY_ADDR, 32'(s * 17));
			repeat (100) @(posedge mclk_i);
			per(0, phy_per[s]);
			chk("freq code", 32'(s), 32'(freq));
		end
		$display("test phy source done");
		for (int t = 0; t < 4; t++)
		begin
			v = $urandom & 32'h0003_031f;
			// First two passes drive every select both ways
			if (t == 0)
				v = v & 32'hffff_ffe0;
			if (t == 1)
				v = v | 32'h0002_021f;
			wr_reg(PERI_CTL_ADDR, v);
			rd_reg(PERI_CTL_ADDR, v);
			repeat (200) @(posedge mclk_i);
			rd_reg(STATUS_ADDR, {22'h0, 2'b11, 1'b0, v[4:0], 2'b11});
			per(4, v[0] ? 8 : 6 * (int'(v[9:8]) + 1));
			per(5, v[1] ? 8 : 6 * (int'(v[9:8]) + 1));
			per(6, 26 * (int'(v[17:16]) + 1));
			per(7, v[2] ? 22 : 12);
			per(11, v[3] ? 22 : 12);
			per(12, v[4] ? 24 : 18);
			per(13, v[4] ? 48 : 36);
		end
		$display("test peripheral selects done");
		wr_reg(PLL_CTL_ADDR, 32'h3);
		repeat (3) @(posedge mclk_i);
		chk("bypass", 32'h0, 32'(byp));
		$display("test pll enable done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
